// File: core/tfu_top.sv
`timescale 1ns/100ps
module tfu_top (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_bus_reset,
  input wire logic i_rom_ok,
  input wire logic i_cond_read_req,
  input wire logic i_overdrive_set,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_byte,
  input wire logic i_tx_req,
  input wire logic i_slot_req,
  input wire logic i_local_supply,
  input wire logic i_port_a_line,
  input wire logic i_port_b_line,
  input wire logic i_port_latch_wr,
  input wire logic [1:0] i_port_latch,
  input wire logic i_conv_done,
  input wire logic [15:0] i_conv_temp,
  output logic o_tx_valid,
  output logic [7:0] o_tx_byte,
  output logic o_slot_valid,
  output logic o_slot_bit,
  output logic o_cond_read_ok,
  output logic o_overdrive_flag,
  output logic o_conv_start,
  output logic [1:0] o_resolution,
  output logic o_port_a_oe,
  output logic o_port_a_out,
  output logic o_port_a_pullup,
  output logic o_port_b_oe,
  output logic o_port_b_out,
  output logic [1:0] o_chain_state
);
  typedef struct packed {
    tfu_pkg::phase_t phase;
    tfu_pkg::busy_t busy;
    tfu_pkg::chain_t chain;
    logic [15:0] temp;
    tfu_pkg::user_bytes_t sp;
    tfu_pkg::user_bytes_t nv;
    logic [3:0] idx;
    logic [3:0] timer;
    logic [7:0] chain_code;
    logic chain_good;
    logic done_sticky;
    logic [1:0] port_latch;
    logic overdrive;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic slot_valid;
    logic slot_bit;
    logic cond_ok;
    logic conv_start;
    logic crc_clear;
    logic crc_load;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [7:0] crc;
  logic [7:0] sp_byte;

  // bits 7 and 4:0 forced on every store
  function automatic logic [7:0] fix_config(input logic [7:0] v);
    return (v & tfu_pkg::CONFIG_RES_MASK) | tfu_pkg::CONFIG_FIXED_ONES;
  endfunction

  function automatic logic [7:0] scratch_at(input state_t s,
                                            input logic [3:0] a);
    case (a)
      4'h0: return s.temp[7:0];
      4'h1: return s.temp[15:8];
      4'h2: return s.sp.high_alarm;
      4'h3: return s.sp.low_alarm;
      4'h4: return s.sp.config_byte;
      4'h5: return tfu_pkg::RESERVED_BYTE5;
      4'h6: return tfu_pkg::RESERVED_BYTE6;
      default: return tfu_pkg::RESERVED_BYTE7;
    endcase
  endfunction

  tfu_crc8 u_crc (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_clear(s_q.crc_clear),
    .i_load(s_q.crc_load),
    .i_data(s_q.tx_byte),
    .o_crc(crc)
  );

  assign sp_byte = scratch_at(s_q, s_q.idx);

  always_comb
  begin
    s_d = s_q;
    s_d.tx_valid = 1'b0;
    s_d.slot_valid = 1'b0;
    s_d.conv_start = 1'b0;
    s_d.crc_clear = 1'b0;
    s_d.crc_load = 1'b0;
    if (i_overdrive_set)
      s_d.overdrive = 1'b1;
    if (s_q.chain == tfu_pkg::CH_OFF && i_port_latch_wr)
      s_d.port_latch = i_port_latch;
    s_d.cond_ok = i_cond_read_req && s_q.chain == tfu_pkg::CH_ON
      && !i_port_b_line;
    if (i_conv_done && s_q.busy == tfu_pkg::BZ_CONV)
      s_d.temp = i_conv_temp;
    if (s_q.busy != tfu_pkg::BZ_NONE && s_q.busy != tfu_pkg::BZ_CONV)
    begin
      if (s_q.timer != 4'h0)
        s_d.timer = s_q.timer - 4'h1;
      else
      begin
        if (s_q.busy == tfu_pkg::BZ_COPY)
          s_d.nv = s_q.sp;
        else
          s_d.sp = s_q.nv;
        s_d.busy = tfu_pkg::BZ_NONE;
        s_d.done_sticky = 1'b1;
      end
    end
    else if (s_q.busy == tfu_pkg::BZ_CONV && i_conv_done)
    begin
      s_d.busy = tfu_pkg::BZ_NONE;
      s_d.done_sticky = 1'b1;
    end
    case (s_q.phase)
      tfu_pkg::ST_ROM:
        if (i_rom_ok)
          s_d.phase = tfu_pkg::ST_CMD;
      tfu_pkg::ST_CMD:
        if (i_rx_valid)
        begin
          s_d.idx = 4'h0;
          s_d.done_sticky = 1'b0;
          case (i_rx_byte)
            tfu_pkg::CMD_WRITE_SP: s_d.phase = tfu_pkg::ST_WRITE;
            tfu_pkg::CMD_READ_SP:
            begin
              s_d.phase = tfu_pkg::ST_READ;
              s_d.crc_clear = 1'b1;
            end
            tfu_pkg::CMD_COPY_SP:
            begin
              s_d.phase = tfu_pkg::ST_BUSY;
              s_d.busy = tfu_pkg::BZ_COPY;
              s_d.timer = tfu_pkg::COPY_CYCLES;
            end
            tfu_pkg::CMD_CONVERT:
            begin
              s_d.phase = tfu_pkg::ST_BUSY;
              s_d.busy = tfu_pkg::BZ_CONV;
              s_d.conv_start = 1'b1;
            end
            tfu_pkg::CMD_RECALL:
            begin
              s_d.phase = tfu_pkg::ST_BUSY;
              s_d.busy = tfu_pkg::BZ_RECALL;
              s_d.timer = tfu_pkg::RECALL_CYCLES;
            end
            tfu_pkg::CMD_POWER: s_d.phase = tfu_pkg::ST_POWER;
            tfu_pkg::CMD_CHAIN: s_d.phase = tfu_pkg::ST_CHAIN_TRUE;
            default: s_d.phase = tfu_pkg::ST_IGNORE;
          endcase
        end
      tfu_pkg::ST_WRITE:
        if (i_rx_valid)
        begin
          case (s_q.idx[1:0])
            2'h0: s_d.sp.high_alarm = i_rx_byte;
            2'h1: s_d.sp.low_alarm = i_rx_byte;
            default: s_d.sp.config_byte = fix_config(i_rx_byte);
          endcase
          s_d.idx = s_q.idx + 4'h1;
          if (s_q.idx[1:0] == tfu_pkg::WRITE_BYTES - 2'h1)
            s_d.phase = tfu_pkg::ST_IGNORE;
        end
      tfu_pkg::ST_READ:
        if (i_tx_req && s_q.idx <= tfu_pkg::SCRATCH_BYTES)
        begin
          s_d.tx_valid = 1'b1;
          if (s_q.idx == tfu_pkg::SCRATCH_BYTES)
            s_d.tx_byte = crc;
          else
          begin
            s_d.tx_byte = sp_byte;
            s_d.crc_load = 1'b1;
          end
          s_d.idx = s_q.idx + 4'h1;
        end
      tfu_pkg::ST_BUSY:
        if (i_slot_req)
        begin
          s_d.slot_valid = 1'b1;
          s_d.slot_bit = s_q.done_sticky;
        end
      tfu_pkg::ST_POWER:
        if (i_slot_req)
        begin
          s_d.slot_valid = 1'b1;
          s_d.slot_bit = i_local_supply;
        end
      tfu_pkg::ST_CHAIN_TRUE:
        if (i_rx_valid)
        begin
          s_d.chain_code = i_rx_byte;
          s_d.phase = tfu_pkg::ST_CHAIN_INV;
        end
      tfu_pkg::ST_CHAIN_INV:
        if (i_rx_valid)
        begin
          s_d.phase = tfu_pkg::ST_CHAIN_ANS;
          s_d.chain_good = 1'b0;
          if (i_rx_byte == ~s_q.chain_code)
          begin
            s_d.chain_good = 1'b1;
            case (s_q.chain_code)
              tfu_pkg::CHAIN_OFF_CODE: s_d.chain = tfu_pkg::CH_OFF;
              tfu_pkg::CHAIN_ON_CODE: s_d.chain = tfu_pkg::CH_ON;
              tfu_pkg::CHAIN_DONE_CODE: s_d.chain = tfu_pkg::CH_DONE;
              default: s_d.chain_good = 1'b0;
            endcase
          end
        end
      tfu_pkg::ST_CHAIN_ANS:
        if (i_tx_req)
        begin
          s_d.tx_valid = 1'b1;
          s_d.tx_byte = s_q.chain_good ? tfu_pkg::CONFIRM_BYTE
            : tfu_pkg::FAIL_BYTE;
        end
      tfu_pkg::ST_IGNORE: s_d.phase = tfu_pkg::ST_IGNORE;
      default: s_d.phase = tfu_pkg::ST_ROM;
    endcase
    if (i_bus_reset)
    begin
      s_d.phase = tfu_pkg::ST_ROM;
      s_d.done_sticky = s_d.done_sticky && s_q.busy != s_d.busy;
      s_d.cond_ok = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      s_q <= '0;
      s_q.phase <= tfu_pkg::ST_BUSY;
      s_q.busy <= tfu_pkg::BZ_RECALL;
      s_q.timer <= tfu_pkg::RECALL_CYCLES;
      s_q.chain <= tfu_pkg::CH_OFF;
      s_q.temp <= tfu_pkg::TEMP_RESET;
      s_q.sp.high_alarm <= tfu_pkg::HIGH_ALARM_RESET;
      s_q.sp.low_alarm <= tfu_pkg::LOW_ALARM_RESET;
      s_q.sp.config_byte <= tfu_pkg::CONFIG_RESET;
      s_q.nv.high_alarm <= tfu_pkg::HIGH_ALARM_RESET;
      s_q.nv.low_alarm <= tfu_pkg::LOW_ALARM_RESET;
      s_q.nv.config_byte <= tfu_pkg::CONFIG_RESET;
      s_q.port_latch <= 2'h3;
      s_q.overdrive <= 1'b0;
    end
    else
      s_q <= s_d;
  end

  // latch 0 turns the pulldown on only in chain off; done forces port a low
  assign o_port_a_oe = (s_q.chain == tfu_pkg::CH_DONE)
    || (s_q.chain == tfu_pkg::CH_OFF && !s_q.port_latch[0]);
  assign o_port_a_out = 1'b0;
  assign o_port_a_pullup = s_q.chain == tfu_pkg::CH_ON;
  assign o_port_b_oe = s_q.chain == tfu_pkg::CH_OFF && !s_q.port_latch[1];
  assign o_port_b_out = 1'b0;
  assign o_tx_valid = s_q.tx_valid;
  assign o_tx_byte = s_q.tx_byte;
  assign o_slot_valid = s_q.slot_valid;
  assign o_slot_bit = s_q.slot_bit;
  assign o_cond_read_ok = s_q.cond_ok;
  assign o_overdrive_flag = s_q.overdrive;
  assign o_conv_start = s_q.conv_start;
  assign o_resolution = {s_q.sp.config_byte[tfu_pkg::RES_SEL_HI],
    s_q.sp.config_byte[tfu_pkg::RES_SEL_LO]};
  assign o_chain_state = (s_q.chain == tfu_pkg::CH_ON) ? 2'h1
    : (s_q.chain == tfu_pkg::CH_DONE) ? 2'h2 : 2'h0;
endmodule

// File: core/tfu_pkg.sv
package tfu_pkg;
  localparam logic [7:0] CMD_WRITE_SP = 8'h4E;
  localparam logic [7:0] CMD_READ_SP = 8'hBE;
  localparam logic [7:0] CMD_COPY_SP = 8'h48;
  localparam logic [7:0] CMD_CONVERT = 8'h44;
  localparam logic [7:0] CMD_POWER = 8'hB4;
  localparam logic [7:0] CMD_RECALL = 8'hB8;
  localparam logic [7:0] CMD_CHAIN = 8'h99;
  localparam logic [7:0] CHAIN_OFF_CODE = 8'h3C;
  localparam logic [7:0] CHAIN_ON_CODE = 8'h5A;
  localparam logic [7:0] CHAIN_DONE_CODE = 8'h96;
  localparam logic [7:0] CONFIRM_BYTE = 8'hAA;
  localparam logic [7:0] FAIL_BYTE = 8'h00;
  localparam logic [2:0] ADDR_HIGH_ALARM = 3'h2;
  localparam logic [2:0] ADDR_LOW_ALARM = 3'h3;
  localparam logic [2:0] ADDR_CONFIG = 3'h4;
  localparam int RES_SEL_HI = 6;
  localparam int RES_SEL_LO = 5;
  localparam logic [7:0] CONFIG_FIXED_ONES = 8'h1F;
  localparam logic [7:0] CONFIG_RES_MASK = 8'h60;
  localparam logic [7:0] CONFIG_RESET = 8'h7F;
  localparam logic [7:0] HIGH_ALARM_RESET = 8'h00;
  localparam logic [7:0] LOW_ALARM_RESET = 8'h00;
  localparam logic [15:0] TEMP_RESET = 16'h0550;
  localparam logic [7:0] RESERVED_BYTE5 = 8'hFF;
  localparam logic [7:0] RESERVED_BYTE6 = 8'h0C;
  localparam logic [7:0] RESERVED_BYTE7 = 8'h10;
  localparam logic [7:0] CRC_POLY = 8'h8C;
  localparam logic [3:0] RECALL_CYCLES = 4'h4;
  localparam logic [3:0] COPY_CYCLES = 4'h8;
  localparam logic [3:0] SCRATCH_BYTES = 4'h8;
  localparam logic [1:0] WRITE_BYTES = 2'h3;

  typedef enum {CH_OFF, CH_ON, CH_DONE} chain_t;
  typedef enum {ST_ROM, ST_CMD, ST_WRITE, ST_READ, ST_BUSY, ST_POWER,
    ST_CHAIN_TRUE, ST_CHAIN_INV, ST_CHAIN_ANS, ST_IGNORE} phase_t;
  typedef enum {BZ_NONE, BZ_COPY, BZ_CONV, BZ_RECALL} busy_t;

  typedef struct packed {
    logic [7:0] high_alarm;
    logic [7:0] low_alarm;
    logic [7:0] config_byte;
  } user_bytes_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } byte_req_t;
endpackage

// File: core/tfu_crc8.sv
`timescale 1ns/100ps
module tfu_crc8 (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [7:0] i_data,
  output logic [7:0] o_crc
);
  typedef struct packed {
    logic [7:0] crc;
  } crc_state_t;

  crc_state_t s_q;
  crc_state_t s_d;

  // one byte per load, bits shifted lsb first
  function automatic logic [7:0] crc_byte(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
    begin
      if (r[0] ^ d[i])
        r = (r >> 1) ^ tfu_pkg::CRC_POLY;
      else
        r = r >> 1;
    end
    return r;
  endfunction

  always_comb
  begin
    s_d = s_q;
    if (i_clear)
      s_d.crc = 8'h00;
    else if (i_load)
      s_d.crc = crc_byte(s_q.crc, i_data);
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign o_crc = s_q.crc;
endmodule

// File: verification/tfu_top_properties.sv
`timescale 1ns/100ps
module tfu_checker (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_tx_req,
  input wire logic i_slot_req,
  input wire logic i_cond_read_req,
  input wire logic i_overdrive_set,
  input wire logic i_port_b_line,
  input wire logic i_port_latch_wr,
  input wire logic o_tx_valid,
  input wire logic o_slot_valid,
  input wire logic o_cond_read_ok,
  input wire logic o_overdrive_flag,
  input wire logic o_conv_start,
  input wire logic o_port_a_oe,
  input wire logic o_port_a_out,
  input wire logic o_port_a_pullup,
  input wire logic o_port_b_oe,
  input wire logic o_port_b_out,
  input wire logic [1:0] o_chain_state
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_arst_n);

  tx_answer_a: assert property (o_tx_valid |-> $past(i_tx_req))
    else $error("tx byte without request");
  slot_answer_a: assert property (o_slot_valid |-> $past(i_slot_req))
    else $error("slot bit without request");
  cond_gate_a: assert property ($past(i_cond_read_req) |->
    o_cond_read_ok == ($past(o_chain_state) == 2'h1 && !$past(i_port_b_line)))
    else $error("conditional read answer wrong");
  done_pull_a: assert property (o_chain_state == 2'h2 |-> o_port_a_oe)
    else $error("done state without pulldown");
  on_pullup_a: assert property (o_port_a_pullup == (o_chain_state == 2'h1))
    else $error("pullup not tied to chain on");
  drain_low_a: assert property (!o_port_a_out && !o_port_b_out)
    else $error("open drain output driven high");
  od_cause_a: assert property ($rose(o_overdrive_flag) |->
    $past(i_overdrive_set))
    else $error("overdrive set without request");
  od_keep_a: assert property (o_overdrive_flag |=> o_overdrive_flag)
    else $error("overdrive flag dropped");
  conv_pulse_a: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start longer than a cycle");
  latch_lock_a: assert property (i_port_latch_wr && o_chain_state == 2'h1
    |=> $stable(o_port_b_oe))
    else $error("latch write honoured outside chain off");

  cover property (o_chain_state == 2'h2);
  cover property (o_cond_read_ok);
  cover property (o_conv_start);
endmodule

bind tfu_top tfu_checker u_chk (.i_sys_clk, .i_arst_n, .i_tx_req,
  .i_slot_req, .i_cond_read_req, .i_overdrive_set, .i_port_b_line,
  .i_port_latch_wr, .o_tx_valid, .o_slot_valid, .o_cond_read_ok,
  .o_overdrive_flag, .o_conv_start, .o_port_a_oe, .o_port_a_out,
  .o_port_a_pullup, .o_port_b_oe, .o_port_b_out, .o_chain_state);

// File: verification/tfu_far_model.sv
`timescale 1ns/100ps
module tfu_far_model #(
  parameter int CONV_CYCLES = 6
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_conv_start,
  input wire logic i_a_oe,
  input wire logic i_b_oe,
  input wire logic i_en_low,
  output logic o_conv_done,
  output logic [15:0] o_conv_temp,
  output logic o_a_line,
  output logic o_b_line
);
  int cnt = 0;
  // released pins float high through the pullups, except line b while en_low pulls it low
  assign o_a_line = !i_a_oe;
  assign o_b_line = !(i_b_oe || i_en_low);
  assign o_conv_done = (cnt == 1);
  // result only meaningful with done, junk otherwise
  assign o_conv_temp = o_conv_done ? 16'h0191 : 16'hFE6E;
  always @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      cnt <= 0;
    else if (i_conv_start)
      cnt <= CONV_CYCLES;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
endmodule

// File: verification/tfu_top_tb_top.sv
`timescale 1ns/100ps
module tfu_top_tb_top;
  logic i_sys_clk = 1'b0, i_arst_n = 1'b0, i_bus_reset = 1'b0;
  logic i_rom_ok = 1'b0, i_cond_read_req = 1'b0, i_overdrive_set = 1'b0;
  logic i_rx_valid = 1'b0, i_tx_req = 1'b0, i_slot_req = 1'b0;
  logic i_local_supply = 1'b1, i_port_latch_wr = 1'b0, en_low = 1'b0;
  logic [7:0] i_rx_byte = 8'h00;
  logic [1:0] i_port_latch = 2'h3;
  logic i_port_a_line, i_port_b_line, i_conv_done;
  logic [15:0] i_conv_temp;
  logic o_tx_valid, o_slot_valid, o_slot_bit, o_cond_read_ok;
  logic o_overdrive_flag, o_conv_start, o_port_a_oe, o_port_a_out;
  logic o_port_a_pullup, o_port_b_oe, o_port_b_out;
  logic [7:0] o_tx_byte;
  logic [1:0] o_resolution, o_chain_state;
  logic [7:0] sp [8];
  int num_errors = 0;
  int checks = 0;
  localparam int EEPROM_WRITE_TIME = 12;
  localparam int CONVERSION_TIME = 10;

  always #25 i_sys_clk = ~i_sys_clk;

  tfu_top u_dut (.i_sys_clk, .i_arst_n, .i_bus_reset, .i_rom_ok,
    .i_cond_read_req, .i_overdrive_set, .i_rx_valid, .i_rx_byte, .i_tx_req,
    .i_slot_req, .i_local_supply, .i_port_a_line, .i_port_b_line,
    .i_port_latch_wr, .i_port_latch, .i_conv_done, .i_conv_temp,
    .o_tx_valid, .o_tx_byte, .o_slot_valid, .o_slot_bit, .o_cond_read_ok,
    .o_overdrive_flag, .o_conv_start, .o_resolution, .o_port_a_oe,
    .o_port_a_out, .o_port_a_pullup, .o_port_b_oe, .o_port_b_out,
    .o_chain_state);

  tfu_far_model u_far (.i_sys_clk, .i_arst_n, .i_conv_start(o_conv_start),
    .i_a_oe(o_port_a_oe), .i_b_oe(o_port_b_oe), .i_en_low(en_low),
    .o_conv_done(i_conv_done), .o_conv_temp(i_conv_temp),
    .o_a_line(i_port_a_line), .o_b_line(i_port_b_line));

  task automatic tick;
    @(posedge i_sys_clk);
    #1;
  endtask

  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic pulse(ref logic s);
    tick;
    s = 1'b1;
    tick;
    s = 1'b0;
  endtask

  task automatic send(input logic [7:0] b);
    i_rx_byte = b;
    pulse(i_rx_valid);
  endtask

  task automatic get(input logic v, input logic [7:0] e);
    pulse(i_tx_req);
    chk("tx", {v, e}, {o_tx_valid, o_tx_byte & {8{v}}});
  endtask

  task automatic slot(input logic e);
    pulse(i_slot_req);
    chk("slot", {1'b1, e}, {o_slot_valid, o_slot_bit});
  endtask

  task automatic cond(input logic e);
    pulse(i_cond_read_req);
    chk("cond", e, o_cond_read_ok);
  endtask

  // parasite power: no read slots, strong pullup for the worst-case time
  task automatic hold_pullup(input int n);
    repeat (n) tick;
  endtask

  task automatic start(input logic [7:0] c);
    pulse(i_bus_reset);
    pulse(i_rom_ok);
    send(c);
  endtask

  task automatic busy;
    int i;
    slot(1'b0);
    for (i = 0; i < 40 && o_slot_bit !== 1'b1; i++)
      pulse(i_slot_req);
    chk("busy", 1'b1, o_slot_bit);
    slot(1'b1);
    slot(1'b1);
  endtask

  task automatic readsp;
    int i;
    int k;
    logic [7:0] c;
    logic [7:0] b;
    c = 8'h00;
    start(tfu_pkg::CMD_READ_SP);
    for (i = 0; i < 8; i++)
    begin
      get(1'b1, sp[i]);
      b = sp[i];
      for (k = 0; k < 8; k++)
      begin
        c = ((c[0] ^ b[0]) == 1'b1) ? ((c >> 1) ^ 8'h8C) : (c >> 1);
        b = b >> 1;
      end
    end
    get(1'b1, c);
    get(1'b0, 8'h00);
  endtask

  task automatic wr(input logic [7:0] h, l, c);
    start(tfu_pkg::CMD_WRITE_SP);
    send(h);
    send(l);
    send(c);
  endtask

  task automatic chain(input logic [7:0] code, inv, ok, input logic [1:0] st);
    start(tfu_pkg::CMD_CHAIN);
    send(code);
    send(inv);
    get(1'b1, ok);
    get(1'b1, ok);
    chk("chain", st, o_chain_state);
  endtask

  task automatic complete_run;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    #2000000;
    num_errors++;
    complete_run;
  end

  initial
  begin
    int r;
    sp = '{8'h50, 8'h05, 8'h00, 8'h00, 8'h7F, 8'hFF, 8'h0C, 8'h10};
    repeat (3) @(posedge i_sys_clk);
    #1 i_arst_n = 1'b1;
    chk("res", 2'h3, o_resolution);
    chk("ports", 2'h0, {o_port_a_oe, o_port_b_oe});
    chk("chain", 2'h0, o_chain_state);
    chk("od", 1'b0, o_overdrive_flag);
    repeat (10) tick;
    start(tfu_pkg::CMD_RECALL);
    busy;
    readsp;
    for (r = 0; r < 4; r++)
    begin
      wr({6'h08, r[1:0]}, {6'h30, r[1:0]}, {1'b1, r[1:0], 5'h00});
      send(8'h00);
      chk("res", r[1:0], o_resolution);
      sp[2] = {6'h08, r[1:0]};
      sp[3] = {6'h30, r[1:0]};
      sp[4] = {1'b0, r[1:0], 5'h1F};
      readsp;
    end
    start(tfu_pkg::CMD_COPY_SP);
    busy;
    wr(8'h01, 8'h02, 8'h00);
    chk("res", 2'h0, o_resolution);
    start(tfu_pkg::CMD_RECALL);
    busy;
    readsp;
    start(tfu_pkg::CMD_CONVERT);
    busy;
    sp[0] = 8'h91;
    sp[1] = 8'h01;
    readsp;
    start(tfu_pkg::CMD_POWER);
    slot(1'b1);
    i_local_supply = 1'b0;
    slot(1'b0);
    start(tfu_pkg::CMD_COPY_SP);
    hold_pullup(EEPROM_WRITE_TIME);
    slot(1'b1);
    start(tfu_pkg::CMD_CONVERT);
    hold_pullup(CONVERSION_TIME);
    slot(1'b1);
    i_local_supply = 1'b1;
    pulse(i_bus_reset);
    wr(8'h00, 8'h00, 8'h00);
    pulse(i_bus_reset);
    send(tfu_pkg::CMD_WRITE_SP);
    send(8'h00);
    send(8'h00);
    send(8'h60);
    chk("res", 2'h0, o_resolution);
    i_port_latch = 2'h0;
    pulse(i_port_latch_wr);
    chk("ports", 2'h3, {o_port_a_oe, o_port_b_oe});
    i_port_latch = 2'h3;
    pulse(i_port_latch_wr);
    chk("ports", 2'h0, {o_port_a_oe, o_port_b_oe});
    // discovery walk: on, refused changes, done, then off
    chain(tfu_pkg::CHAIN_ON_CODE, ~tfu_pkg::CHAIN_ON_CODE,
      tfu_pkg::CONFIRM_BYTE, 2'h1);
    chk("pullup", 1'b1, o_port_a_pullup);
    cond(1'b0);
    en_low = 1'b1;
    cond(1'b1);
    i_port_latch = 2'h0;
    pulse(i_port_latch_wr);
    chk("ports", 2'h0, {o_port_a_oe, o_port_b_oe});
    chain(tfu_pkg::CHAIN_DONE_CODE, 8'h00, tfu_pkg::FAIL_BYTE, 2'h1);
    chain(8'h77, 8'h88, tfu_pkg::FAIL_BYTE, 2'h1);
    chain(tfu_pkg::CHAIN_DONE_CODE, ~tfu_pkg::CHAIN_DONE_CODE,
      tfu_pkg::CONFIRM_BYTE, 2'h2);
    chk("pull_a", 1'b1, o_port_a_oe);
    cond(1'b0);
    chain(tfu_pkg::CHAIN_OFF_CODE, ~tfu_pkg::CHAIN_OFF_CODE,
      tfu_pkg::CONFIRM_BYTE, 2'h0);
    chk("pull_a", 1'b0, o_port_a_oe);
    cond(1'b0);
    en_low = 1'b0;
    pulse(i_overdrive_set);
    chk("od", 1'b1, o_overdrive_flag);
    complete_run;
  end
endmodule
